// file: design/tsp_timer_sync.sv
// timer two overflow flag, async clock select, update-busy flags and prescaler reset control
`timescale 1ns/1ps
`default_nettype none
`include "tsp_regs.svh"

// Summary of operation
// - overflow flag sets whenever the eight-bit counter overflows.
// - overflow flag clears when the processor enters its interrupt vector.
// - writing one to the overflow flag clears it; zero leaves it.
// - interrupt requested only when global enable, overflow enable and flag are one.
// - in PWM mode flag sets when counter turns direction at bottom.
// - external clock bit plus async select enables the oscillator pin input buffer.
// - crystal oscillator runs only while the external clock bit is zero.
// - async select zero clocks from io clock, one from oscillator pin.
// - async write to a timer register sets its busy flag until transferred.
// - busy flag zero means that register accepts a new value.
// - sync mode holds both written prescaler reset bits, halting the timers.
// - writing sync mode zero clears both prescaler reset bits together.
// - async prescaler reset bit resets prescaler and clears unless sync mode.
// - written in async operation, it reads one until the reset completes.
// - shared prescaler reset bit clears immediately unless sync mode is active.
// - general control register also reachable in short io space, offset minus displacement.
module tsp_timer_sync
  import tsp_pkg::*;
(
  input  wire logic       MCLK_I,
  input  wire logic       RESET_I,
  input  wire logic [7:0] ADDR_I,
  input  wire logic       IO_SPACE_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       GLOBAL_IRQ_EN_I,
  input  wire logic       OVF_VECTOR_ACK_I,
  input  wire logic       TIMER_OSC_PIN_I,
  output logic      [7:0] RDATA_O,
  output logic            OVF_IRQ_O,
  output logic            EXT_BUF_EN_O,
  output logic            OSC_RUN_O,
  output logic            ASYNC_PRESC_RST_O,
  output logic            SHARED_PRESC_RST_O,
  output logic      [7:0] COUNT_O
);

  tsp_state_t r;
  tsp_state_t r_nxt;
  tsp_bus_t   bus;
  logic       osc_edge;
  logic       tick;
  logic       count_en;
  logic       ovf_set;
  logic       ovf_clr;
  logic       wr_gen;
  logic       wr_cnt;
  logic [9:0] tap;

  // ****************************************
  // bus decode
  // ****************************************
  always_comb begin
    bus.wdata = WDATA_I;
    bus.wr    = WR_I;
    bus.rd    = RD_I;
    if (IO_SPACE_I) begin
      bus.addr = 8'(ADDR_I + `TSP_IO_DISP);
    end else begin
      bus.addr = ADDR_I;
    end
  end

  assign wr_gen = bus.wr && (bus.addr == `TSP_OFF_GEN);
  assign wr_cnt = bus.wr && (bus.addr == `TSP_OFF_CNT);

  // ****************************************
  // timer clock source and prescaler taps
  // ****************************************
  assign osc_edge = r.osc_s2 && !r.osc_s3;
  assign tick     = r.asel ? osc_edge : 1'b1;

  always_comb begin
    case (r.tregs.ctlb[2:0])
      3'h2:    tap = `TSP_MASK_DIV8;
      3'h3:    tap = `TSP_MASK_DIV32;
      3'h4:    tap = `TSP_MASK_DIV64;
      3'h5:    tap = `TSP_MASK_DIV128;
      3'h6:    tap = `TSP_MASK_DIV256;
      3'h7:    tap = `TSP_MASK_DIV1024;
      default: tap = `TSP_MASK_DIV1;
    endcase
  end

  // a held async prescaler reset (apr) stops counting; the shared one (spr) does not
  assign count_en = tick && !r.apr && (r.tregs.ctlb[2:0] != 3'h0) &&
                    ((r.presc & tap) == tap);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    r_nxt   = r;
    ovf_set = 1'b0;
    ovf_clr = OVF_VECTOR_ACK_I;

    r_nxt.osc_s1 = TIMER_OSC_PIN_I;
    r_nxt.osc_s2 = r.osc_s1;
    r_nxt.osc_s3 = r.osc_s2;

    // prescaler and counter
    if (r.apr && tick) begin
      r_nxt.presc = 10'h000;
    end else if (tick && (r.tregs.ctlb[2:0] != 3'h0)) begin
      r_nxt.presc = r.presc + 10'h001;
    end
    if (count_en) begin
      if (r.tregs.ctla[`TSP_BIT_PWM]) begin
        if (r.dir == TSP_UP) begin
          if (r.tregs.cnt == `TSP_TOP) begin
            r_nxt.dir       = TSP_DOWN;
            r_nxt.tregs.cnt = r.tregs.cnt - 8'h01;
          end else begin
            r_nxt.tregs.cnt = r.tregs.cnt + 8'h01;
          end
        end else if (r.tregs.cnt == `TSP_BOTTOM) begin
          r_nxt.dir       = TSP_UP;
          r_nxt.tregs.cnt = r.tregs.cnt + 8'h01;
          ovf_set         = 1'b1;
        end else begin
          r_nxt.tregs.cnt = r.tregs.cnt - 8'h01;
        end
      end else begin
        r_nxt.dir       = TSP_UP;
        r_nxt.tregs.cnt = r.tregs.cnt + 8'h01;
        ovf_set         = (r.tregs.cnt == `TSP_TOP);
      end
    end

    // temporary storage moves into the timer registers on an oscillator tick
    if (r.asel && osc_edge) begin
      if (r.busy[`TSP_BUSY_CNT]) begin
        r_nxt.tregs.cnt = r.temp.cnt;
      end
      if (r.busy[`TSP_BUSY_CMPA]) begin
        r_nxt.tregs.cmpa = r.temp.cmpa;
      end
      if (r.busy[`TSP_BUSY_CMPB]) begin
        r_nxt.tregs.cmpb = r.temp.cmpb;
      end
      if (r.busy[`TSP_BUSY_CTLA]) begin
        r_nxt.tregs.ctla = r.temp.ctla;
      end
      if (r.busy[`TSP_BUSY_CTLB]) begin
        r_nxt.tregs.ctlb = r.temp.ctlb;
      end
      r_nxt.busy = 5'h00;
    end

    // prescaler reset bits release unless sync mode holds them
    if (!r.sync_mode) begin
      if (tick) begin
        r_nxt.apr = 1'b0;
      end
      r_nxt.spr = 1'b0;
    end

    // register writes
    if (bus.wr) begin
      if (bus.addr == `TSP_OFF_GEN) begin
        r_nxt.sync_mode = bus.wdata[`TSP_BIT_SYNC];
        if (r.sync_mode && !bus.wdata[`TSP_BIT_SYNC]) begin
          r_nxt.apr = 1'b0;
          r_nxt.spr = 1'b0;
        end else begin
          r_nxt.apr = bus.wdata[`TSP_BIT_APR] || (r.apr && !tick);
          r_nxt.spr = bus.wdata[`TSP_BIT_SPR];
        end
      end else if (bus.addr == `TSP_OFF_STAT) begin
        r_nxt.ext  = bus.wdata[`TSP_BIT_EXT];
        r_nxt.asel = bus.wdata[`TSP_BIT_ASEL];
      end else if (bus.addr == `TSP_OFF_MASK) begin
        r_nxt.ovie = bus.wdata[`TSP_BIT_OVIE];
      end else if (bus.addr == `TSP_OFF_FLAG) begin
        ovf_clr = ovf_clr || bus.wdata[`TSP_BIT_OVF];
      end else if (r.asel) begin
        // async operation: stage the value and flag it busy
        if (bus.addr == `TSP_OFF_CNT) begin
          r_nxt.temp.cnt = bus.wdata;
          r_nxt.busy[`TSP_BUSY_CNT] = 1'b1;
        end else if (bus.addr == `TSP_OFF_CMPA) begin
          r_nxt.temp.cmpa = bus.wdata;
          r_nxt.busy[`TSP_BUSY_CMPA] = 1'b1;
        end else if (bus.addr == `TSP_OFF_CMPB) begin
          r_nxt.temp.cmpb = bus.wdata;
          r_nxt.busy[`TSP_BUSY_CMPB] = 1'b1;
        end else if (bus.addr == `TSP_OFF_CTLA) begin
          r_nxt.temp.ctla = bus.wdata;
          r_nxt.busy[`TSP_BUSY_CTLA] = 1'b1;
        end else if (bus.addr == `TSP_OFF_CTLB) begin
          r_nxt.temp.ctlb = bus.wdata;
          r_nxt.busy[`TSP_BUSY_CTLB] = 1'b1;
        end
      end else begin
        if (bus.addr == `TSP_OFF_CNT) begin
          r_nxt.tregs.cnt = bus.wdata;
        end else if (bus.addr == `TSP_OFF_CMPA) begin
          r_nxt.tregs.cmpa = bus.wdata;
        end else if (bus.addr == `TSP_OFF_CMPB) begin
          r_nxt.tregs.cmpb = bus.wdata;
        end else if (bus.addr == `TSP_OFF_CTLA) begin
          r_nxt.tregs.ctla = bus.wdata;
        end else if (bus.addr == `TSP_OFF_CTLB) begin
          r_nxt.tregs.ctlb = bus.wdata;
        end
      end
    end

    // a new overflow beats a clear in the same cycle
    r_nxt.ovf = ovf_set || (r.ovf && !ovf_clr);

    // register reads
    r_nxt.rdata = `TSP_RST_BYTE;
    if (bus.rd) begin
      if (bus.addr == `TSP_OFF_GEN) begin
        r_nxt.rdata = {r.sync_mode, 5'h00, r.apr, r.spr};
      end else if (bus.addr == `TSP_OFF_STAT) begin
        r_nxt.rdata = {1'b0, r.ext, r.asel, r.busy};
      end else if (bus.addr == `TSP_OFF_MASK) begin
        r_nxt.rdata = {7'h00, r.ovie};
      end else if (bus.addr == `TSP_OFF_FLAG) begin
        r_nxt.rdata = {7'h00, r.ovf};
      end else if (bus.addr == `TSP_OFF_CNT) begin
        r_nxt.rdata = r.tregs.cnt;
      end else if (bus.addr == `TSP_OFF_CMPA) begin
        r_nxt.rdata = r.tregs.cmpa;
      end else if (bus.addr == `TSP_OFF_CMPB) begin
        r_nxt.rdata = r.tregs.cmpb;
      end else if (bus.addr == `TSP_OFF_CTLA) begin
        r_nxt.rdata = r.tregs.ctla;
      end else if (bus.addr == `TSP_OFF_CTLB) begin
        r_nxt.rdata = r.tregs.ctlb;
      end
    end

    // outputs
    r_nxt.irq     = GLOBAL_IRQ_EN_I && r.ovie && r.ovf;
    r_nxt.ext_buf = r.ext && r.asel;
    r_nxt.osc_run = !r.ext;
    r_nxt.apr_o   = r.apr;
    r_nxt.spr_o   = r.spr;
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign RDATA_O            = r.rdata;
  assign OVF_IRQ_O          = r.irq;
  assign EXT_BUF_EN_O       = r.ext_buf;
  assign OSC_RUN_O          = r.osc_run;
  assign ASYNC_PRESC_RST_O  = r.apr_o;
  assign SHARED_PRESC_RST_O = r.spr_o;
  assign COUNT_O            = r.tregs.cnt;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);

  sequence s_async_cnt_write;
    r.asel && wr_cnt && !osc_edge;
  endsequence

  sequence s_osc_transfer;
    r.busy[`TSP_BUSY_CNT] && r.asel && osc_edge && !wr_cnt;
  endsequence

  a_ovf_set_wins: assert property (ovf_set |=> r.ovf)
    else $error("overflow event lost");
  a_ovf_vector_clr: assert property (OVF_VECTOR_ACK_I && !ovf_set |=> !r.ovf)
    else $error("vector entry did not clear overflow flag");
  a_ovf_write_one: assert property (
    bus.wr && bus.addr == `TSP_OFF_FLAG && !ovf_set |=>
    r.ovf == ($past(r.ovf) && !$past(bus.wdata[0]) && !$past(OVF_VECTOR_ACK_I)))
    else $error("overflow flag write-one clear wrong");
  a_irq_gate: assert property (
    OVF_IRQ_O == ($past(GLOBAL_IRQ_EN_I) && $past(r.ovie) && $past(r.ovf)))
    else $error("overflow request not gated by enables");
  a_pwm_bottom: assert property (
    count_en && r.tregs.ctla[0] && r.dir == TSP_DOWN && r.tregs.cnt == 8'h00 |=>
    r.ovf && r.dir == TSP_UP)
    else $error("bottom reversal did not set overflow");
  a_ext_buffer: assert property (##1 EXT_BUF_EN_O == $past(r.ext && r.asel))
    else $error("external buffer enable wrong");
  a_osc_run: assert property (r.ext && $past(r.ext) |-> !OSC_RUN_O)
    else $error("crystal runs with external clock");
  a_busy_set: assert property (s_async_cnt_write |=> r.busy[4])
    else $error("async counter write did not set busy");
  a_busy_release: assert property (
    s_osc_transfer |=> !r.busy[4] && r.tregs.cnt == $past(r.temp.cnt))
    else $error("busy cleared without counter transfer");
  a_sync_hold: assert property (
    r.sync_mode && r.apr && r.spr && !wr_gen |=> r.apr && r.spr)
    else $error("sync mode did not hold prescaler resets");
  a_sync_release: assert property (
    r.sync_mode && wr_gen && !bus.wdata[7] |=> !r.apr && !r.spr ##1 !SHARED_PRESC_RST_O)
    else $error("sync mode exit did not clear resets");
  a_shared_pulse: assert property (r.spr && !r.sync_mode && !wr_gen |=> !r.spr)
    else $error("shared prescaler reset did not self clear");
  a_async_pending: assert property (
    r.apr && r.asel && !osc_edge && !r.sync_mode && !wr_gen |=> r.apr)
    else $error("async prescaler reset cleared early");
  a_io_alias: assert property (
    WR_I && IO_SPACE_I && ADDR_I == 8'h23 && WDATA_I[7] |=> r.sync_mode)
    else $error("short io alias of general control missed");

endmodule
`default_nettype wire

// file: design/tsp_regs.svh
// register offsets, bit positions, reset values and prescaler taps of the timer sync block
`ifndef TSP_REGS_SVH
`define TSP_REGS_SVH

// ****************************************
// offsets in data space
// ****************************************
`define TSP_OFF_GEN      8'h43
`define TSP_OFF_STAT     8'hB6
`define TSP_OFF_CTLA     8'hB0
`define TSP_OFF_CTLB     8'hB1
`define TSP_OFF_CNT      8'hB2
`define TSP_OFF_CMPA     8'hB3
`define TSP_OFF_CMPB     8'hB4
`define TSP_OFF_MASK     8'h70
`define TSP_OFF_FLAG     8'h37
`define TSP_IO_DISP      8'h20

// ****************************************
// field positions
// ****************************************
`define TSP_BIT_SYNC     7
`define TSP_BIT_APR      1
`define TSP_BIT_SPR      0
`define TSP_BIT_EXT      6
`define TSP_BIT_ASEL     5
`define TSP_BIT_OVF      0
`define TSP_BIT_OVIE     0
`define TSP_BIT_PWM      0
`define TSP_BUSY_CNT     4
`define TSP_BUSY_CMPA    3
`define TSP_BUSY_CMPB    2
`define TSP_BUSY_CTLA    1
`define TSP_BUSY_CTLB    0

// ****************************************
// reset values and counter limits
// ****************************************
`define TSP_RST_BYTE     8'h00
`define TSP_BOTTOM       8'h00
`define TSP_TOP          8'hFF

// ****************************************
// prescaler tap masks per clock select
// ****************************************
`define TSP_MASK_DIV1    10'h000
`define TSP_MASK_DIV8    10'h007
`define TSP_MASK_DIV32   10'h01F
`define TSP_MASK_DIV64   10'h03F
`define TSP_MASK_DIV128  10'h07F
`define TSP_MASK_DIV256  10'h0FF
`define TSP_MASK_DIV1024 10'h3FF

`endif

// file: design/tsp_pkg.sv
// types shared by the timer sync block
`default_nettype none
package tsp_pkg;

  typedef enum logic {TSP_UP, TSP_DOWN} tsp_dir_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] cmpa;
    logic [7:0] cmpb;
    logic [7:0] ctla;
    logic [7:0] ctlb;
  } tsp_tregs_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tsp_bus_t;

  typedef struct packed {
    tsp_tregs_t  tregs;
    tsp_tregs_t  temp;
    logic [4:0]  busy;
    logic        ext;
    logic        asel;
    logic        sync_mode;
    logic        apr;
    logic        spr;
    logic        ovf;
    logic        ovie;
    logic [9:0]  presc;
    tsp_dir_t    dir;
    logic        osc_s1;
    logic        osc_s2;
    logic        osc_s3;
    logic [7:0]  rdata;
    logic        irq;
    logic        ext_buf;
    logic        osc_run;
    logic        apr_o;
    logic        spr_o;
  } tsp_state_t;

endpackage
`default_nettype wire

// file: verification/tsp_timer_sync_tb.sv
// self-checking bench for the timer sync block
`timescale 1ns/1ps
`default_nettype none
`include "tsp_regs.svh"

module tsp_timer_sync_tb;
  localparam int LIMIT = 5000;

  logic       clk, rst, io_sp, wr_en, rd_en, gie, vec_ack, osc_pin;
  logic [7:0] addr, wdata, rdata, count;
  logic       irq, ext_buf, osc_run, apr, spr;
  logic       seen_spr = 1'b0;
  logic       seen_apr = 1'b0;
  int         err_total = 0;
  int         comparisons = 0;
  int         cycles = 0;

  tsp_timer_sync dut_u (
    .MCLK_I            (clk),
    .RESET_I           (rst),
    .ADDR_I            (addr),
    .IO_SPACE_I        (io_sp),
    .WR_I              (wr_en),
    .RD_I              (rd_en),
    .WDATA_I           (wdata),
    .GLOBAL_IRQ_EN_I   (gie),
    .OVF_VECTOR_ACK_I  (vec_ack),
    .TIMER_OSC_PIN_I   (osc_pin),
    .RDATA_O           (rdata),
    .OVF_IRQ_O         (irq),
    .EXT_BUF_EN_O      (ext_buf),
    .OSC_RUN_O         (osc_run),
    .ASYNC_PRESC_RST_O (apr),
    .SHARED_PRESC_RST_O(spr),
    .COUNT_O           (count)
  );

  // ****************************************
  // clock, timeout and pulse catchers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (!rst) begin
      seen_spr <= seen_spr | spr;
      seen_apr <= seen_apr | apr;
    end
    if (cycles >= LIMIT) begin
      err_total++;
      $display("ERROR at %0t: run did not finish in time", $time);
      end_sim();
    end else begin
      cycles++;
    end
  end

  // ****************************************
  // access tasks
  // ****************************************
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic io = 1'b0);
    @(negedge clk);
    addr = a;
    wdata = d;
    io_sp = io;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
    io_sp = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic io = 1'b0);
    @(negedge clk);
    addr = a;
    io_sp = io;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    io_sp = 1'b0;
    chk(rdata, exp, "read data");
  endtask

  // one oscillator period, long enough for the pin synchronizer
  task automatic tick();
    osc_pin = 1'b1;
    idle(5);
    osc_pin = 1'b0;
    idle(5);
  endtask

  task automatic ovf_run(input logic [7:0] start);
    wr(`TSP_OFF_CNT, start);
    wr(`TSP_OFF_CTLB, 8'h01);
    idle(12);
    wr(`TSP_OFF_CTLB, 8'h00);
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    rst = 1'b1;
    io_sp = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    gie = 1'b0;
    vec_ack = 1'b0;
    osc_pin = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    idle(5);
    rst = 1'b0;
    idle(2);
    rd(`TSP_OFF_GEN, 8'h00);
    rd(`TSP_OFF_STAT, 8'h00);
    rd(`TSP_OFF_MASK, 8'h00);
    rd(`TSP_OFF_FLAG, 8'h00);
    rd(8'h50, 8'h00);
    chk({7'h00, osc_run}, 8'h01, "osc run");
    chk({7'h00, ext_buf}, 8'h00, "ext buf");
    $display("test reset done");

    wr(8'h23, 8'h80, 1'b1);
    rd(`TSP_OFF_GEN, 8'h80);
    rd(8'h23, 8'h80, 1'b1);
    wr(`TSP_OFF_GEN, 8'h00);
    rd(`TSP_OFF_GEN, 8'h00);
    $display("test io space done");

    wr(`TSP_OFF_GEN, 8'h03);
    idle(3);
    rd(`TSP_OFF_GEN, 8'h00);
    chk({7'h00, seen_spr}, 8'h01, "shared");
    chk({7'h00, seen_apr}, 8'h01, "async");
    wr(`TSP_OFF_GEN, 8'h83);
    idle(4);
    rd(`TSP_OFF_GEN, 8'h83);
    chk({6'h00, apr, spr}, 8'h03, "held");
    wr(`TSP_OFF_GEN, 8'h00);
    idle(2);
    rd(`TSP_OFF_GEN, 8'h00);
    chk({6'h00, apr, spr}, 8'h00, "freed");
    $display("test prescaler reset done");

    wr(`TSP_OFF_STAT, 8'h40);
    idle(2);
    chk({7'h00, osc_run}, 8'h00, "osc run");
    chk({7'h00, ext_buf}, 8'h00, "ext buf");
    wr(`TSP_OFF_STAT, 8'h60);
    idle(2);
    chk({7'h00, ext_buf}, 8'h01, "ext buf");
    wr(`TSP_OFF_STAT, 8'hFF);
    rd(`TSP_OFF_STAT, 8'h60);
    wr(`TSP_OFF_STAT, 8'h00);
    idle(2);
    chk({6'h00, osc_run, ext_buf}, 8'h02, "clock src");
    $display("test clock source done");

    wr(`TSP_OFF_STAT, 8'h20);
    wr(`TSP_OFF_CNT, 8'h55);
    wr(`TSP_OFF_CMPA, 8'hAA);
    wr(`TSP_OFF_CMPB, 8'h5A);
    wr(`TSP_OFF_CTLA, 8'h00);
    wr(`TSP_OFF_CTLB, 8'h00);
    rd(`TSP_OFF_STAT, 8'h3F);
    chk(count, 8'h00, "count staged");
    tick();
    rd(`TSP_OFF_STAT, 8'h20);
    chk(count, 8'h55, "count moved");
    rd(`TSP_OFF_CMPA, 8'hAA);
    rd(`TSP_OFF_CMPB, 8'h5A);
    wr(`TSP_OFF_GEN, 8'h02);
    idle(4);
    rd(`TSP_OFF_GEN, 8'h02);
    tick();
    rd(`TSP_OFF_GEN, 8'h00);
    wr(`TSP_OFF_STAT, 8'h00);
    wr(`TSP_OFF_CMPA, 8'h00);
    $display("test async update done");

    ovf_run(8'hF8);
    rd(`TSP_OFF_STAT, 8'h00);
    rd(`TSP_OFF_FLAG, 8'h01);
    gie = 1'b1;
    idle(2);
    chk({7'h00, irq}, 8'h00, "irq");
    wr(`TSP_OFF_MASK, 8'h01);
    idle(2);
    chk({7'h00, irq}, 8'h01, "irq");
    gie = 1'b0;
    idle(2);
    chk({7'h00, irq}, 8'h00, "irq");
    gie = 1'b1;
    wr(`TSP_OFF_FLAG, 8'h00);
    rd(`TSP_OFF_FLAG, 8'h01);
    wr(`TSP_OFF_FLAG, 8'h01);
    rd(`TSP_OFF_FLAG, 8'h00);
    chk({7'h00, irq}, 8'h00, "irq");
    ovf_run(8'hF8);
    idle(2);
    chk({7'h00, irq}, 8'h01, "irq");
    vec_ack = 1'b1;
    idle(1);
    vec_ack = 1'b0;
    rd(`TSP_OFF_FLAG, 8'h00);
    chk({7'h00, irq}, 8'h00, "irq");
    $display("test overflow done");

    wr(`TSP_OFF_CTLA, 8'h01);
    wr(`TSP_OFF_CNT, 8'h02);
    wr(`TSP_OFF_CTLB, 8'h01);
    idle(300);
    rd(`TSP_OFF_FLAG, 8'h00);
    idle(300);
    rd(`TSP_OFF_FLAG, 8'h01);
    wr(`TSP_OFF_CTLB, 8'h00);
    $display("test pwm bottom done");

    // divide-by-eight tap, started together by leaving sync mode
    wr(`TSP_OFF_CTLA, 8'h00);
    wr(`TSP_OFF_GEN, 8'h82);
    wr(`TSP_OFF_CNT, 8'h00);
    wr(`TSP_OFF_CTLB, 8'h02);
    idle(20);
    chk(count, 8'h00, "count held");
    wr(`TSP_OFF_GEN, 8'h00);
    idle(44);
    chk(count, 8'h05, "count div8");
    rd(`TSP_OFF_CTLB, 8'h02);
    rd(`TSP_OFF_CTLA, 8'h00);
    wr(`TSP_OFF_CTLB, 8'h00);
    $display("test prescaler tap done");
    end_sim();
  end
endmodule

`default_nettype wire
